// ### common/pwm_channel_defines.vh
`ifndef PWM_CHANNEL_DEFINES_VH
`define PWM_CHANNEL_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_MODE 8'h00
`define OFF_DUTY 8'h04
`define OFF_PERIOD 8'h08
`define OFF_COUNTER 8'h0c
`define OFF_UPDATE 8'h10
`define OFF_ENABLE 8'h14
`define OFF_DISABLE 8'h18
`define OFF_STATUS 8'h1c
`define OFF_EVENT 8'h20
`define OFF_DIVIDER 8'h24

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_PRE_HI 3
`define MODE_PRE_LO 0
`define MODE_ALIGN 8
`define MODE_LEVEL 9
`define MODE_TARGET 10
`define MODE_MASK 32'h0000070f

// ----------------------------------------
// Divider register fields
// ----------------------------------------
`define DIVIDER_A_FACTOR_HI 7
`define DIVIDER_A_FACTOR_LO 0
`define PREA_HI 11
`define PREA_LO 8
`define DIVIDER_B_FACTOR_HI 23
`define DIVIDER_B_FACTOR_LO 16
`define PREB_HI 27
`define PREB_LO 24
`define DIVIDER_MASK 32'h0fff0fff

// ----------------------------------------
// Encodings and widths
// ----------------------------------------
`define CNT_W 16
`define PRE_W 10
`define PRE_MAX 4'ha
`define PRE_SHARED_CLOCK_A 4'hb
`define PRE_SHARED_CLOCK_B 4'hc
`define PRE_ONES 10'h3ff
`define HTRANS_NONSEQ_BIT 1
`define ENABLE_BIT 0
`define EVENT_BIT 0
`define HRESP_OKAY 1'b0

`endif

// ### core/pwm_channel_waveform.v
`timescale 1ns/1ps
`include "pwm_channel_defines.vh"

module pwm_channel_waveform (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg pwm_out,
  output wire period_flag
);

  // ----------------------------------------
  // Prescaler tick select
  // ----------------------------------------
  function pre_tick;
    input [3:0] code;
    input [`PRE_W-1:0] cnt;
    reg [`PRE_W-1:0] m;
    begin
      m = ~(`PRE_ONES << code);
      pre_tick = (code <= `PRE_MAX) && ((cnt & m) == m);
    end
  endfunction

  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  reg [7:0] addr_r;
  reg wr_r;
  reg rd_r;
  reg [31:0] mode_r;
  reg [`CNT_W-1:0] duty_r;
  reg [`CNT_W-1:0] period_r;
  reg [`CNT_W-1:0] pending_r;
  reg pending_vld_r;
  reg [31:0] divider_r;
  reg enabled_r;
  reg event_r;
  reg [`CNT_W-1:0] cnt_r;
  reg down_r;
  reg [`PRE_W-1:0] pre_cnt_r;
  wire [1:0] shared_tick;
  wire [3:0] ch_pre;
  wire ch_tick;
  wire period_start;
  wire wr_mode;
  wire wr_duty;
  wire wr_period;
  wire wr_update;
  wire wr_enable;
  wire wr_disable;
  wire wr_divider;
  wire rd_event;
  wire level;
  reg [`CNT_W-1:0] cnt_nxt;
  reg down_nxt;
  reg start_nxt;

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (hready) begin
      addr_r <= haddr[7:0];
      wr_r <= hsel & htrans[`HTRANS_NONSEQ_BIT] & hwrite;
      rd_r <= hsel & htrans[`HTRANS_NONSEQ_BIT] & ~hwrite;
    end
  end

  assign wr_mode = wr_r && (addr_r == `OFF_MODE);
  assign wr_duty = wr_r && (addr_r == `OFF_DUTY);
  assign wr_period = wr_r && (addr_r == `OFF_PERIOD);
  assign wr_update = wr_r && (addr_r == `OFF_UPDATE);
  assign wr_enable = wr_r && (addr_r == `OFF_ENABLE) && hwdata[`ENABLE_BIT];
  assign wr_disable = wr_r && (addr_r == `OFF_DISABLE) && hwdata[`ENABLE_BIT];
  assign wr_divider = wr_r && (addr_r == `OFF_DIVIDER);
  assign rd_event = rd_r && (addr_r == `OFF_EVENT);

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------

  // Read mux in the data phase; update register reads as zero
  always @* begin
    hrdata = 32'h00000000;
    if (rd_r) begin
      case (addr_r)
        `OFF_MODE: hrdata = mode_r;
        `OFF_DUTY: hrdata = {16'h0000, duty_r};
        `OFF_PERIOD: hrdata = {16'h0000, period_r};
        `OFF_COUNTER: hrdata = {16'h0000, cnt_r};
        `OFF_STATUS: hrdata = {31'h00000000, enabled_r};
        `OFF_EVENT: hrdata = {31'h00000000, event_r};
        `OFF_DIVIDER: hrdata = divider_r;
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= 32'h00000000;
      divider_r <= 32'h00000000;
      enabled_r <= 1'b0;
    end else begin
      if (wr_mode)
        mode_r <= hwdata & `MODE_MASK;
      if (wr_divider)
        divider_r <= hwdata & `DIVIDER_MASK;
      if (wr_enable)
        enabled_r <= 1'b1;
      else if (wr_disable)
        enabled_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Master clock prescaler and shared clocks
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pre_cnt_r <= {`PRE_W{1'b0}};
    else
      pre_cnt_r <= pre_cnt_r + 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : shared_clk
      reg [7:0] div_cnt_r;
      wire [7:0] factor;
      wire [3:0] pre_sel;
      wire src_tick;
      assign factor = (g == 0) ? divider_r[`DIVIDER_A_FACTOR_HI:`DIVIDER_A_FACTOR_LO] : divider_r[`DIVIDER_B_FACTOR_HI:`DIVIDER_B_FACTOR_LO];
      assign pre_sel = (g == 0) ? divider_r[`PREA_HI:`PREA_LO] : divider_r[`PREB_HI:`PREB_LO];
      assign src_tick = pre_tick(pre_sel, pre_cnt_r);
      // Factor zero stops the clock, one passes it, more divides
      assign shared_tick[g] = (factor != 8'h00) && src_tick
                              && (div_cnt_r >= factor - 8'h01);
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          div_cnt_r <= 8'h00;
        else if (factor == 8'h00)
          div_cnt_r <= 8'h00;
        else if (src_tick)
          div_cnt_r <= shared_tick[g] ? 8'h00 : div_cnt_r + 8'h01;
      end
    end
  endgenerate

  assign ch_pre = mode_r[`MODE_PRE_HI:`MODE_PRE_LO];
  assign ch_tick = (ch_pre == `PRE_SHARED_CLOCK_A) ? shared_tick[0] :
                   (ch_pre == `PRE_SHARED_CLOCK_B) ? shared_tick[1] :
                   pre_tick(ch_pre, pre_cnt_r);

  // ----------------------------------------
  // Channel counter
  // ----------------------------------------
  always @* begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    start_nxt = 1'b0;
    if (!mode_r[`MODE_ALIGN]) begin
      // Values 0..period-1, so one period is period ticks
      if (cnt_r + 1'b1 >= period_r) begin
        cnt_nxt = {`CNT_W{1'b0}};
        start_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end else if (period_r == {`CNT_W{1'b0}}) begin
      cnt_nxt = {`CNT_W{1'b0}};
      down_nxt = 1'b0;
      start_nxt = 1'b1;
    end else if (!down_r) begin
      // Up to period, then down to zero: twice period ticks
      cnt_nxt = cnt_r + 1'b1;
      down_nxt = (cnt_r + 1'b1 >= period_r);
    end else if (cnt_r <= {{(`CNT_W-1){1'b0}}, 1'b1}) begin
      cnt_nxt = {`CNT_W{1'b0}};
      down_nxt = 1'b0;
      start_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  assign period_start = enabled_r && ch_tick && start_nxt;

  // ----------------------------------------
  // Counter register
  // ----------------------------------------

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {`CNT_W{1'b0}};
      down_r <= 1'b0;
    end else if (wr_enable) begin
      cnt_r <= {`CNT_W{1'b0}};
      down_r <= 1'b0;
    end else if (enabled_r && ch_tick) begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // ----------------------------------------
  // Duty, period and double buffer
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      duty_r <= {`CNT_W{1'b0}};
      period_r <= {`CNT_W{1'b0}};
      pending_r <= {`CNT_W{1'b0}};
      pending_vld_r <= 1'b0;
    end else begin
      if (wr_duty)
        duty_r <= hwdata[`CNT_W-1:0];
      if (wr_period)
        period_r <= hwdata[`CNT_W-1:0];
      if (wr_update) begin
        pending_r <= hwdata[`CNT_W-1:0];
        pending_vld_r <= 1'b1;
      end else if (period_start && pending_vld_r) begin
        // Only at a period boundary, so the running period stays whole
        pending_vld_r <= 1'b0;
        if (mode_r[`MODE_TARGET])
          period_r <= pending_r;
        else
          duty_r <= pending_r;
      end
    end
  end

  // ----------------------------------------
  // Period event flag and output
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      event_r <= 1'b0;
    else if (period_start)
      event_r <= 1'b1;
    else if (rd_event)
      event_r <= 1'b0;
  end

  assign period_flag = event_r;

  // ----------------------------------------
  // Waveform output
  // ----------------------------------------
  // Duty above period is software's fault; output then holds start level
  assign level = (cnt_r < duty_r) ? mode_r[`MODE_LEVEL] : ~mode_r[`MODE_LEVEL];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pwm_out <= 1'b0;
    else
      pwm_out <= enabled_r ? level : 1'b0;
  end

endmodule // pwm_channel_waveform

// ### bench/pwm_channel_waveform_monitor.sv
`timescale 1ns/1ps
module pwm_channel_waveform_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire pwm_out,
  input wire period_flag
);
  // ----------------------------------------
  // Data phase and enable tracking
  // ----------------------------------------
  reg rd_r;
  reg wr_r;
  reg en_r;
  reg [7:0] off_r;
  wire take = hsel && htrans[1] && hready;
  wire evt_rd = rd_r && off_r == 8'h20;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      en_r <= 1'b0;
      off_r <= 8'h00;
    end else begin
      rd_r <= take && !hwrite;
      wr_r <= take && hwrite;
      off_r <= haddr[7:0];
      if (wr_r && hwdata[0] && off_r == 8'h14) en_r <= 1'b1;
      else if (wr_r && hwdata[0] && off_r == 8'h18) en_r <= 1'b0;
    end
  end
  default clocking mon_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_WO_READS_ZERO:
    assert property (rd_r && (off_r == 8'h10 || off_r > 8'h24) |-> hrdata == 32'h0)
    else $error("update or unmapped read not zero");
  AST_UPPER_ZERO:
    assert property (rd_r && off_r inside {8'h04, 8'h08, 8'h0c} |-> hrdata[31:16] == 16'h0)
    else $error("upper half of 16-bit register not zero");
  AST_MODE_BITS:
    assert property (rd_r && off_r == 8'h00 |-> (hrdata & ~32'h0000070f) == 32'h0)
    else $error("mode register unused bits set");
  AST_STATUS_EN:
    assert property (rd_r && off_r == 8'h1c |-> hrdata[0] == en_r)
    else $error("status does not follow enable writes");
  AST_FLAG_CLEAR:
    assert property ($fell(period_flag) |-> $past(evt_rd))
    else $error("period flag dropped without event read");
  AST_FLAG_ENABLED:
    assert property ($rose(period_flag) |-> $past(en_r))
    else $error("period flag set while disabled");
  AST_EVENT_READ:
    assert property (evt_rd |-> hrdata[0] == period_flag)
    else $error("event read differs from flag");
  AST_OFF_LOW:
    assert property (!en_r && !$past(en_r) |-> !pwm_out)
    else $error("output high while disabled");
  cover property (wr_r && off_r == 8'h14);
  cover property ($rose(period_flag));
  cover property (evt_rd && hrdata[0]);
endmodule // pwm_channel_waveform_monitor

bind pwm_channel_waveform pwm_channel_waveform_monitor i_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out), .period_flag(period_flag));

// ### bench/pwm_channel_waveform_bench.sv
`timescale 1ns/1ps
module pwm_channel_waveform_bench;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h0;
  reg [31:0] hwdata = 32'h0;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire pwm_out;
  wire period_flag;
  int num_errors = 0;
  int n_tests = 0;
  int i;
  logic [31:0] v;
  logic [31:0] n;
  always #5 hclk = ~hclk;
  pwm_channel_waveform i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pwm_out(pwm_out),
    .period_flag(period_flag));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      n_tests++;
      if (s !== e) begin
        num_errors++;
        $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      v = hrdata;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(v, e);
      chk({31'h0, hresp}, 32'h0);
    end
  endtask
  task setup(input logic [31:0] m);
    begin
      wr(8'h00, m);
      wr(8'h14, 32'h1);
    end
  endtask
  // Cycles between two rising edges of the output
  task per(output logic [31:0] t);
    logic p;
    int k;
    int j;
    begin
      t = 0;
      k = 0;
      p = 1'b1;
      for (j = 0; j < 12000 && k < 2; j++) begin
        @(negedge hclk);
        if (k > 0) t = t + 1;
        if (pwm_out === 1'b1 && p === 1'b0) k++;
        p = pwm_out;
      end
    end
  endtask
  task give_verdict;
    begin
      $display("tests %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #400000;
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i <= 48; i += 4) rd(i[7:0], 32'h0);
    $display("test reset values done");
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'h0000070f);
    wr(8'h08, 32'hffff1234);
    wr(8'h04, 32'habcd1234);
    rd(8'h04, 32'h00001234);
    rd(8'h08, 32'h00001234);
    wr(8'h10, 32'h4);
    rd(8'h10, 32'h0);
    wr(8'h08, 32'h4);
    wr(8'h04, 32'h4);
    for (i = 0; i < 2; i++) begin
      setup(i ? 32'h0 : 32'h200);
      repeat (6) @(posedge hclk);
      chk(pwm_out, i ? 32'h0 : 32'h1);
    end
    $display("test levels done");
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h5);
    for (i = 0; i <= 10; i++) begin
      setup(i);
      per(n);
      chk(n, 32'd5 << i);
      xfer(1'b0, 8'h0c, 32'h0);
      chk(v < 5, 32'h1);
    end
    wr(8'h08, 32'h4);
    wr(8'h04, 32'h1);
    setup(32'h100);
    per(n);
    chk(n, 32'd8);
    wr(8'h24, 32'h103);
    wr(8'h04, 32'h2);
    setup(32'hb);
    per(n);
    chk(n, 32'd24);
    $display("test waveform periods done");
    wr(8'h08, 32'h8);
    setup(32'h2);
    per(n);
    wr(8'h10, 32'h6);
    rd(8'h04, 32'h2);
    repeat (80) @(posedge hclk);
    rd(8'h04, 32'h6);
    wr(8'h04, 32'h2);
    setup(32'h402);
    per(n);
    wr(8'h10, 32'ha);
    rd(8'h08, 32'h8);
    per(n);
    per(n);
    chk(n, 32'd40);
    rd(8'h08, 32'ha);
    $display("test update done");
    wr(8'h00, 32'hc);
    wr(8'h14, 32'h1);
    rd(8'h0c, 32'h0);
    repeat (20) @(posedge hclk);
    rd(8'h0c, 32'h0);
    rd(8'h20, 32'h1);
    rd(8'h20, 32'h0);
    chk(period_flag, 32'h0);
    rd(8'h1c, 32'h1);
    wr(8'h18, 32'h1);
    rd(8'h1c, 32'h0);
    wr(8'h14, 32'h0);
    rd(8'h1c, 32'h0);
    chk(pwm_out, 32'h0);
    $display("test enable and events done");
    give_verdict;
  end
endmodule // pwm_channel_waveform_bench
